//--- core/uwd_pkg.sv
// uwd_pkg: constants shared by the activity watchdog core
// assumes a 40 MHz system clock and an AXI4-Lite register port with 32-bit data
package uwd_pkg;

  // ==========================================================================
  // timing
  localparam int unsigned CLK_FREQ_HZ     = 40_000_000;
  localparam int unsigned TICK_PERIOD_MS  = 1000;
  localparam int unsigned TICK_CYCLES     = TICK_PERIOD_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned TICK_CNT_W      = 26;

  // ==========================================================================
  // register map (byte addresses)
  localparam int unsigned AXI_ADDR_W      = 8;
  localparam logic [7:0]  REG_COMMAND     = 8'h00;
  localparam logic [7:0]  REG_OPTIONS     = 8'h04;
  localparam logic [7:0]  REG_LIMIT       = 8'h08;
  localparam logic [7:0]  REG_LINE_SELECT = 8'h0c;
  localparam logic [7:0]  REG_STATUS      = 8'h10;
  localparam logic [7:0]  REG_COUNTER     = 8'h14;

  // ==========================================================================
  // field layout
  localparam int unsigned CMD_WRITE_BIT   = 0;
  localparam int unsigned OPT_RESET_BIT   = 5;
  localparam int unsigned OPT_LINE_BIT    = 4;
  localparam int unsigned SEL_LEVEL_BIT   = 7;
  localparam int unsigned SEL_INDEX_LSB   = 0;
  localparam int unsigned SEL_INDEX_W     = 5;
  localparam int unsigned NUM_LINES       = 20;
  localparam logic [4:0]  FIRST_GROUP_END = 5'h07;
  localparam logic [4:0]  SECOND_GROUP_END= 5'h0f;
  localparam logic [4:0]  THIRD_GROUP_END = 5'h13;
  localparam int unsigned STAT_ARMED_BIT  = 0;
  localparam int unsigned STAT_FIRED_BIT  = 1;
  localparam int unsigned STAT_BUSY_BIT   = 2;
  localparam int unsigned STAT_PKT_LSB    = 8;
  localparam logic [15:0] LIMIT_MIN       = 16'h0003;

  // ==========================================================================
  // reset values and bus answers
  localparam logic [7:0]  OPTIONS_RESET   = 8'h00;
  localparam logic [15:0] LIMIT_RESET     = 16'h0000;
  localparam logic [7:0]  SELECT_RESET    = 8'h00;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  localparam int unsigned NVM_IMAGE_W     = 32;

  // control sequence, gray coded along load -> run -> program
  typedef enum logic [1:0] {
    ST_LOAD = 2'b00,
    ST_RUN  = 2'b01,
    ST_PROG = 2'b11
  } uwd_state_t;

endpackage

//--- core/uwd_watchdog.sv
// uwd_watchdog: host-activity watchdog with stored settings and timeout actions
// assumes a single 40 MHz clock, an AXI4-Lite master, pulse inputs synchronous
// to clk, and an external non-volatile store with a request/done handshake
//
// Function
// - counter runs only while the stored options byte is nonzero
// - every incoming host transfer clears the counter to zero
// - outgoing sample packets never clear the counter
// - reaching the timeout limit performs every selected action
// - counter ticks about once a second; limit 3 to 65535
// - options bit 5 resets device, bit 4 drives selected line
// - select byte: level in bit 7, line index in bits 0-4
// - index 0-7 first group, 8-15 second, 16-19 third group
// - settings kept in non-volatile store; a command write with bit 0 set while the store is idle programs it
// - jumper short at power-up zeroes all stored settings
//
// Added by the designer: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module uwd_watchdog
  import uwd_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input  wire logic                    clk,
  input  wire logic                    reset_n,
  // axi4-lite slave
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                    s_axi_awvalid,
  output logic                         s_axi_awready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  input  wire logic                    s_axi_wvalid,
  output logic                         s_axi_wready,
  output logic [1:0]                   s_axi_bresp,
  output logic                         s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  input  wire logic [AXI_ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                    s_axi_arvalid,
  output logic                         s_axi_arready,
  output logic [31:0]                  s_axi_rdata,
  output logic [1:0]                   s_axi_rresp,
  output logic                         s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  // link activity
  input  wire logic                    host_transfer_in,
  input  wire logic                    sample_packet_out,
  // power-up strap and settings store
  input  wire logic                    jumper_return_pin,
  input  wire logic [NVM_IMAGE_W-1:0]  nvm_load_data,
  output logic                         nvm_write_req,
  output logic [NVM_IMAGE_W-1:0]       nvm_write_data,
  input  wire logic                    nvm_write_done,
  // timeout actions
  output logic                         device_reset_req,
  output logic [7:0]                   first_line_group_en,
  output logic [7:0]                   first_line_group_level,
  output logic [7:0]                   second_line_group_en,
  output logic [7:0]                   second_line_group_level,
  output logic [3:0]                   third_line_group_en,
  output logic [3:0]                   third_line_group_level
);

  // ==========================================================================
  // state record
  typedef struct packed {
    uwd_state_t            state;
    logic [7:0]            options;
    logic [15:0]           limit;
    logic [7:0]            line_select;
    logic [7:0]            stage_options;
    logic [15:0]           stage_limit;
    logic [7:0]            stage_select;
    logic [TICK_CNT_W-1:0] tick_cnt;
    logic [15:0]           wd_cnt;
    logic                  fired;
    logic                  dev_reset;
    logic [NUM_LINES-1:0]  force_en;
    logic [NUM_LINES-1:0]  force_level;
    logic [7:0]            out_pkts;
    logic                  nvm_req;
    logic [NVM_IMAGE_W-1:0] nvm_image;
    logic                  aw_full;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic                  w_full;
    logic [31:0]           w_data;
    logic [3:0]            w_strb;
    logic                  awready;
    logic                  wready;
    logic                  bvalid;
    logic [1:0]            bresp;
    logic                  arready;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } uwd_regs_t;

  uwd_regs_t r;
  uwd_regs_t next_r;

  // ==========================================================================
  // helpers

  // merge one register with the enabled byte lanes of a bus write
  function automatic logic [31:0] merge_bytes(input logic [31:0] old_val,
                                              input logic [31:0] new_val,
                                              input logic [3:0]  strb);
    logic [31:0] res;
    res = old_val;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = new_val[8*i +: 8];
    end
    return res;
  endfunction

  // index to line decode
  // an index past the third group selects nothing rather than aliasing
  function automatic logic [NUM_LINES-1:0] line_onehot(input logic [4:0] idx);
    logic [NUM_LINES-1:0] res;
    res = '0;
    if (idx <= THIRD_GROUP_END) res[idx] = 1'b1;
    return res;
  endfunction

  // effective limit floor
  // values below the floor would fire almost at once after any host traffic
  function automatic logic [15:0] eff_limit(input logic [15:0] lim);
    return (lim < LIMIT_MIN) ? LIMIT_MIN : lim;
  endfunction

  // ==========================================================================
  // next-state logic
  always_comb begin
    logic                 wr_go;
    logic                 rd_go;
    logic                 commit;
    logic                 armed;
    logic [31:0]          merged;
    logic [NUM_LINES-1:0] sel_mask;
    logic [TICK_CNT_W-1:0] tick_last;

    next_r    = r;
    commit    = 1'b0;
    wr_go     = 1'b0;
    rd_go     = 1'b0;
    armed     = 1'b0;
    merged    = '0;
    tick_last = TICK_CNT_W'(TICK_LEN - 1);
    sel_mask  = line_onehot(r.line_select[SEL_INDEX_LSB +: SEL_INDEX_W]);
    next_r.dev_reset = 1'b0;

    // write channel capture, address and data in either order
    if (s_axi_awvalid && r.awready) begin
      next_r.aw_full = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.wready) begin
      next_r.w_full = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) next_r.bvalid = 1'b0;

    // perform a write once both halves are held
    wr_go = r.aw_full && r.w_full && !r.bvalid;
    if (wr_go) begin
      next_r.aw_full = 1'b0;
      next_r.w_full  = 1'b0;
      next_r.bvalid  = 1'b1;
      next_r.bresp   = RESP_OKAY;
      unique case (r.aw_addr)
        REG_COMMAND: begin
          // settings write commits
          // a commit while the store is busy is dropped, not queued
          commit = r.w_strb[0] && r.w_data[CMD_WRITE_BIT] && (r.state == ST_RUN);
        end
        REG_OPTIONS: begin
          merged = merge_bytes({24'h000000, r.stage_options}, r.w_data, r.w_strb);
          next_r.stage_options = merged[7:0];
        end
        REG_LIMIT: begin
          merged = merge_bytes({16'h0000, r.stage_limit}, r.w_data, r.w_strb);
          next_r.stage_limit = merged[15:0];
        end
        REG_LINE_SELECT: begin
          merged = merge_bytes({24'h000000, r.stage_select}, r.w_data, r.w_strb);
          next_r.stage_select = merged[7:0];
        end
        REG_STATUS, REG_COUNTER: next_r.bresp = RESP_OKAY;
        default:                 next_r.bresp = RESP_SLVERR;
      endcase
    end

    // read channel
    if (r.rvalid && s_axi_rready) next_r.rvalid = 1'b0;
    rd_go = s_axi_arvalid && r.arready;
    if (rd_go) begin
      next_r.rvalid = 1'b1;
      next_r.rresp  = RESP_OKAY;
      next_r.rdata  = '0;
      unique case (s_axi_araddr)
        REG_COMMAND:     next_r.rdata = '0;
        REG_OPTIONS:     next_r.rdata[7:0]  = r.options;
        REG_LIMIT:       next_r.rdata[15:0] = r.limit;
        REG_LINE_SELECT: next_r.rdata[7:0]  = r.line_select;
        REG_STATUS: begin
          next_r.rdata[STAT_ARMED_BIT] = (r.options != OPTIONS_RESET);
          next_r.rdata[STAT_FIRED_BIT] = r.fired;
          next_r.rdata[STAT_BUSY_BIT]  = (r.state != ST_RUN);
          next_r.rdata[STAT_PKT_LSB +: 8] = r.out_pkts;
        end
        REG_COUNTER:     next_r.rdata[15:0] = r.wd_cnt;
        default:         next_r.rresp = RESP_SLVERR;
      endcase
    end

    // outgoing packets only counted
    // the outgoing tally is diagnostic and has no path to the counter
    if (sample_packet_out) next_r.out_pkts = r.out_pkts + 8'h01;

    // control sequence and settings store
    unique case (r.state)
      ST_LOAD: begin
        // jumper clears settings
        // the strap is caught in the first clocked cycle after release
        if (jumper_return_pin) begin
          next_r.options     = OPTIONS_RESET;
          next_r.limit       = LIMIT_RESET;
          next_r.line_select = SELECT_RESET;
          next_r.nvm_image   = '0;
          next_r.nvm_req     = 1'b1;
          next_r.state       = ST_PROG;
        end else begin
          next_r.options     = nvm_load_data[7:0];
          next_r.limit       = nvm_load_data[23:8];
          next_r.line_select = nvm_load_data[31:24];
          next_r.nvm_image   = nvm_load_data;
          next_r.state       = ST_RUN;
        end
        next_r.stage_options = next_r.options;
        next_r.stage_limit   = next_r.limit;
        next_r.stage_select  = next_r.line_select;
        next_r.wd_cnt        = '0;
        next_r.tick_cnt      = '0;
      end
      ST_RUN: begin
        if (commit) begin
          next_r.options     = r.stage_options;
          next_r.limit       = r.stage_limit;
          next_r.line_select = r.stage_select;
          next_r.nvm_image   = {r.stage_select, r.stage_limit, r.stage_options};
          next_r.nvm_req     = 1'b1;
          next_r.state       = ST_PROG;
        end
      end
      ST_PROG: begin
        // request stands until the store reports completion
        if (nvm_write_done) begin
          next_r.nvm_req = 1'b0;
          next_r.state   = ST_RUN;
        end
      end
      default: next_r.state = ST_LOAD;
    endcase

    // armed only with nonzero options
    // the store keeps timing while busy so a reconfigure never pauses the guard
    armed = (r.options != OPTIONS_RESET) && (r.state != ST_LOAD);
    if (!armed || commit) begin
      next_r.wd_cnt   = '0;
      next_r.tick_cnt = '0;
      if (commit) next_r.fired = 1'b0;
    end else if (host_transfer_in) begin
      next_r.wd_cnt   = '0;
      next_r.tick_cnt = '0;
      next_r.fired    = 1'b0;
    end else if (!r.fired) begin
      if (r.tick_cnt == tick_last) begin
        next_r.tick_cnt = '0;
        next_r.wd_cnt   = r.wd_cnt + 16'h0001;
        // timeout actions
        // actions fire once per expiry; the counter then holds at the limit
        if (r.wd_cnt + 16'h0001 >= eff_limit(r.limit)) begin
          next_r.fired = 1'b1;
          next_r.dev_reset = r.options[OPT_RESET_BIT];
          if (r.options[OPT_LINE_BIT]) begin
            next_r.force_en = r.force_en | sel_mask;
            if (r.line_select[SEL_LEVEL_BIT]) begin
              next_r.force_level = r.force_level | sel_mask;
            end else begin
              next_r.force_level = r.force_level & ~sel_mask;
            end
          end
        end
      end else begin
        next_r.tick_cnt = r.tick_cnt + TICK_CNT_W'(1);
      end
    end

    // ready flags follow the held state so each channel stalls while full
    next_r.awready = !next_r.aw_full && !next_r.bvalid;
    next_r.wready  = !next_r.w_full && !next_r.bvalid;
    next_r.arready = !next_r.rvalid;
  end

  // ==========================================================================
  // state register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      r <= '{
        state:         ST_LOAD,
        options:       OPTIONS_RESET,
        limit:         LIMIT_RESET,
        line_select:   SELECT_RESET,
        stage_options: OPTIONS_RESET,
        stage_limit:   LIMIT_RESET,
        stage_select:  SELECT_RESET,
        rresp:         RESP_OKAY,
        bresp:         RESP_OKAY,
        default:       '0
      };
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================================
  // outputs, all straight from the state register
  assign s_axi_awready           = r.awready;
  assign s_axi_wready            = r.wready;
  assign s_axi_bvalid            = r.bvalid;
  assign s_axi_bresp             = r.bresp;
  assign s_axi_arready           = r.arready;
  assign s_axi_rvalid            = r.rvalid;
  assign s_axi_rdata             = r.rdata;
  assign s_axi_rresp             = r.rresp;
  assign nvm_write_req           = r.nvm_req;
  assign nvm_write_data          = r.nvm_image;
  assign device_reset_req        = r.dev_reset;
  assign first_line_group_en     = r.force_en[7:0];
  assign first_line_group_level  = r.force_level[7:0];
  assign second_line_group_en    = r.force_en[15:8];
  assign second_line_group_level = r.force_level[15:8];
  assign third_line_group_en     = r.force_en[19:16];
  assign third_line_group_level  = r.force_level[19:16];

endmodule

`default_nettype wire

//--- verification/uwd_store_model.sv
// uwd_store_model: behavioural settings store on the far side of the core
// assumes the req/done handshake and settings image layout of uwd_watchdog
`timescale 1ns/1ps
`default_nettype none
module uwd_store_model
  import uwd_pkg::*;
#(
  parameter logic [NVM_IMAGE_W-1:0] INIT_IMAGE  = 32'h0,
  parameter int unsigned            PROG_CYCLES = 5
) (
  input  wire logic                   clk,
  input  wire logic                   nvm_write_req,
  input  wire logic [NVM_IMAGE_W-1:0] nvm_write_data,
  output logic                        nvm_write_done,
  output logic [NVM_IMAGE_W-1:0]      nvm_load_data
);
  // ==========================================================================
  // storage: contents survive every reset, like the real array
  int unsigned prog_cnt = 0;
  initial nvm_load_data = INIT_IMAGE;
  initial nvm_write_done = 1'b0;
  // one program per request
  // the count parks past the end so a request still high is not programmed twice
  always @(posedge clk) begin
    nvm_write_done <= 1'b0;
    if (!nvm_write_req) begin
      prog_cnt <= 0;
    end else if (prog_cnt == PROG_CYCLES) begin
      nvm_write_done <= 1'b1;
      nvm_load_data  <= nvm_write_data;
      prog_cnt       <= prog_cnt + 1;
    end else if (prog_cnt < PROG_CYCLES) begin
      prog_cnt <= prog_cnt + 1;
    end
  end
endmodule
`default_nettype wire

//--- verification/uwd_watchdog_checker.sv
// uwd_watchdog_checker: port-level assertions for the activity watchdog
// assumes it is bound into every uwd_watchdog and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module uwd_watchdog_checker
  import uwd_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
) (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic                   s_axi_awvalid,
  input wire logic                   s_axi_awready,
  input wire logic                   s_axi_wvalid,
  input wire logic                   s_axi_wready,
  input wire logic                   s_axi_bvalid,
  input wire logic                   s_axi_bready,
  input wire logic                   s_axi_arvalid,
  input wire logic                   s_axi_arready,
  input wire logic                   s_axi_rvalid,
  input wire logic                   s_axi_rready,
  input wire logic [31:0]            s_axi_rdata,
  input wire logic                   host_transfer_in,
  input wire logic                   nvm_write_req,
  input wire logic [NVM_IMAGE_W-1:0] nvm_write_data,
  input wire logic                   nvm_write_done,
  input wire logic                   device_reset_req,
  input wire logic [7:0]             first_line_group_en,
  input wire logic [7:0]             second_line_group_en,
  input wire logic [3:0]             third_line_group_en
);
  // ==========================================================================
  // common clocking; nothing is judged while reset is low
  default clocking dc @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire logic [19:0] forced = {third_line_group_en, second_line_group_en, first_line_group_en};
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // ==========================================================================
  // bus handshakes
  write_answer_a: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  read_answer_a: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped or changed");
  write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  // ==========================================================================
  // watchdog behaviour
  store_hold_a: assert property (nvm_write_req && !nvm_write_done |=> nvm_write_req && $stable(nvm_write_data))
    else $error("store request dropped or image changed");
  reset_pulse_a: assert property (device_reset_req |=> !device_reset_req)
    else $error("device reset request longer than one cycle");
  clear_holdoff_a: assert property (host_transfer_in |=> !device_reset_req [*3])
    else $error("expiry too soon after host transfer");
  lines_sticky_a: assert property (1'b1 |=> (forced & $past(forced)) == $past(forced))
    else $error("forced line released");
endmodule
`default_nettype wire
bind uwd_watchdog uwd_watchdog_checker #(.TICK_LEN(TICK_LEN)) i_uwd_watchdog_checker (.*);

//--- verification/tb_usb_activity_watchdog.sv
// tb_usb_activity_watchdog: self-checking bench for the activity watchdog
// assumes uwd_watchdog with a short tick and the behavioural settings store
`timescale 1ns/1ps
`default_nettype none
module tb_usb_activity_watchdog;
  import uwd_pkg::*;
  localparam int unsigned TL   = 4;
  localparam logic [31:0] BOOT = {8'h85, 16'h0004, 8'h10};
  // limit and select byte per entry; 8'h99 selects a line that does not exist
  // every selected line is taken as already set up as an output
  localparam logic [23:0] GROUPS [6] = '{24'h000392, 24'h000213, 24'h000507,
                                         24'h000388, 24'h00038f, 24'h000399};
  logic        clk = 1'b0, reset_n = 1'b0, jumper_return_pin = 1'b0;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        host_transfer_in = 1'b0, sample_packet_out = 1'b0, streaming = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, nvm_load_data, nvm_write_data;
  logic        nvm_write_req, nvm_write_done, device_reset_req, rst_seen = 1'b0;
  logic [7:0]  first_line_group_en, first_line_group_level;
  logic [7:0]  second_line_group_en, second_line_group_level;
  logic [3:0]  third_line_group_en, third_line_group_level;
  logic [19:0] exp_en = 20'h0, exp_lv = 20'h0;
  int          mismatches = 0, total_checks = 0, cycles = 0;
  wire logic [19:0] cur_en = {third_line_group_en, second_line_group_en, first_line_group_en};
  wire logic [19:0] cur_lv = {third_line_group_level, second_line_group_level,
                              first_line_group_level};

  uwd_watchdog #(.TICK_LEN(TL)) i_uwd_watchdog (.*);
  uwd_store_model #(.INIT_IMAGE(BOOT)) i_uwd_store_model (.*);

  // ==========================================================================
  // clock, outgoing packet stream, reset-request monitor and hang guard
  always #12.5 clk = ~clk;
  always @(posedge clk) sample_packet_out <= streaming & ~sample_packet_out;
  always @(negedge clk) if (device_reset_req === 1'b1) rst_seen = 1'b1;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      $display("Error %0t: timeout", $time);
      end_sim();
    end
  end

  // ==========================================================================
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready));
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= a; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
    do begin
      @(posedge clk);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready));
    d = s_axi_rdata; r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic do_reset(input logic jmp);
    @(posedge clk);
    reset_n <= 1'b0; jumper_return_pin <= jmp; exp_en = 20'h0; exp_lv = 20'h0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
    repeat (2) @(posedge clk);
    jumper_return_pin <= 1'b0;
  endtask
  task automatic store_idle();
    repeat (2) @(posedge clk);
    while (nvm_write_req !== 1'b0) @(negedge clk);
  endtask
  task automatic pulse_host();
    @(posedge clk) host_transfer_in <= 1'b1;
    @(posedge clk) host_transfer_in <= 1'b0;
  endtask
  // each commit waits out a full program cycle before the next
  task automatic commit(input logic [7:0] opt, input logic [15:0] lim, input logic [7:0] sel);
    logic [1:0] r;
    axi_write(REG_OPTIONS, {24'h0, opt}, r);
    axi_write(REG_LIMIT, {16'h0, lim}, r);
    axi_write(REG_LINE_SELECT, {24'h0, sel}, r);
    axi_write(REG_COMMAND, 32'h1, r);
    check(32'(r), 32'(RESP_OKAY));
    store_idle();
    check(nvm_load_data, {sel, lim, opt});
  endtask
  task automatic fire_check(input logic [15:0] lim, input logic [7:0] sel, input logic rst_on);
    int n;
    logic [19:0] old;
    old = cur_en;
    n = -1; // the first negedge still belongs to the clearing edge
    pulse_host();
    do begin
      @(negedge clk);
      n++;
    end while (device_reset_req !== 1'b1 && cur_en === old && n < 300000);
    check(32'(n), 32'((lim < 16'd3 ? 16'd3 : lim) * TL));
    check(32'(device_reset_req), 32'(rst_on));
    if (sel[4:0] < 5'd20) begin
      exp_en[sel[4:0]] = 1'b1;
      exp_lv[sel[4:0]] = sel[7];
    end
    check(32'(cur_en), 32'(exp_en));
    check(32'(cur_lv), 32'(exp_lv));
  endtask
  task automatic rd_check(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check(d & mask, e);
    check(32'(r), 32'(RESP_OKAY));
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_power_load();
    rd_check(REG_OPTIONS, 32'hff, 32'(BOOT[7:0]));
    rd_check(REG_LIMIT, 32'hffff, 32'(BOOT[23:8]));
    rd_check(REG_LINE_SELECT, 32'hff, 32'(BOOT[31:24]));
    rd_check(REG_STATUS, 32'h1, 32'h1);
    fire_check(BOOT[23:8], BOOT[31:24], 1'b0);
    $display("test power_load done");
  endtask
  task automatic t_keep_alive();
    commit(8'h30, 16'd3, 8'h09);
    streaming <= 1'b1;
    rst_seen = 1'b0;
    // clear first: counting began at the commit
    repeat (5) begin
      pulse_host();
      repeat (8) @(posedge clk);
    end
    check(32'(rst_seen), 32'h0);
    fire_check(16'd3, 8'h09, 1'b1);
    streaming <= 1'b0;
    $display("test keep_alive done");
  endtask
  task automatic t_groups();
    foreach (GROUPS[i]) begin
      commit(8'h30, GROUPS[i][23:8], GROUPS[i][7:0]);
      fire_check(GROUPS[i][23:8], GROUPS[i][7:0], 1'b1);
    end
    $display("test groups done");
  endtask
  task automatic t_unmapped();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(8'h20, d, r);
    check(32'(r), 32'(RESP_SLVERR));
    check(d, 32'h0);
    axi_write(8'h18, 32'h1, r);
    check(32'(r), 32'(RESP_SLVERR));
    $display("test unmapped done");
  endtask
  task automatic t_jumper();
    do_reset(1'b1);
    store_idle();
    check(nvm_load_data, 32'h0);
    rd_check(REG_OPTIONS, 32'hff, 32'h0);
    rd_check(REG_STATUS, 32'h1, 32'h0);
    rst_seen = 1'b0;
    repeat (40) @(posedge clk);
    rd_check(REG_COUNTER, 32'hffff, 32'h0);
    check(32'(rst_seen), 32'h0);
    $display("test jumper done");
  endtask

  initial begin
    do_reset(1'b0);
    t_power_load();
    t_keep_alive();
    t_groups();
    t_unmapped();
    t_jumper();
    end_sim();
  end
endmodule
`default_nettype wire
